// *** src/gig_status_cfg.svh ***
// register offsets, field positions and reset values of the gigabit status group
`ifndef GIG_STATUS_CFG_SVH
`define GIG_STATUS_CFG_SVH

`define GSX_ADDR_LINK_STATUS   5'h0a
`define GSX_ADDR_EXT_CTRL      5'h0b
`define GSX_ADDR_EXT_WDATA     5'h0c
`define GSX_ADDR_EXT_RDATA     5'h0d
`define GSX_ADDR_ABILITY       5'h0f

`define GSX_LS_MS_FAULT        15
`define GSX_LS_MS_MASTER       14
`define GSX_LS_LOC_RCVR        13
`define GSX_LS_REM_RCVR        12
`define GSX_LS_LP_FD           11
`define GSX_LS_LP_HD           10
`define GSX_LS_IDLE_CNT_MSB    7

`define GSX_CTRL_DIR           15
`define GSX_CTRL_PAGE          8
`define GSX_CTRL_ADDR_MSB      7

`define GSX_ABILITY_VALUE      16'h3000
`define GSX_WORD_RESET         16'h0000
`define GSX_CNT_RESET          8'h00
`define GSX_CNT_MAX            8'hff

`endif

// *** src/gig_status_pkg.sv ***
// types shared by the gigabit status register group
package gig_status_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [7:0]  err_count_t;
  typedef logic [4:0]  reg_addr_t;
  typedef logic [7:0]  ext_addr_t;
endpackage : gig_status_pkg

// *** src/gigabit_status_ext_access.sv ***
// gigabit link status, ability and extended register window of the management register set
`timescale 1ns/1ps
`include "gig_status_cfg.svh"

module gigabit_status_ext_access (
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_RST_N,
  input  wire gig_status_pkg::reg_addr_t  I_REG_ADDR,
  input  wire logic                       I_REG_WR,
  input  wire logic                       I_REG_RD,
  input  wire gig_status_pkg::reg_word_t  I_REG_WDATA,
  output var  gig_status_pkg::reg_word_t  O_REG_RDATA,
  output logic                            O_REG_RVALID,
  input  wire logic                       I_MS_FAULT,
  input  wire logic                       I_MS_MASTER,
  input  wire logic                       I_LOC_RCVR_OK,
  input  wire logic                       I_REM_RCVR_OK,
  input  wire logic                       I_PARTNER_GIG_FULL_DUPLEX,
  input  wire logic                       I_PARTNER_GIG_HALF_DUPLEX,
  input  wire logic                       I_SYMBOL_EN,
  input  wire logic                       I_RX_IDLE,
  input  wire logic                       I_TX_SEND_N,
  input  wire logic                       I_RX_ERROR,
  output logic                            O_EXT_WR,
  output logic                            O_EXT_RD,
  output logic                            O_EXT_PAGE,
  output var  gig_status_pkg::ext_addr_t  O_EXT_ADDR,
  output var  gig_status_pkg::reg_word_t  O_EXT_WDATA,
  input  wire gig_status_pkg::reg_word_t  I_EXT_RDATA
);

  // decoded accesses and idle error condition
  logic rd_status;
  logic wr_ctrl;
  logic wr_data;
  logic idle_err;

  assign rd_status = I_REG_RD && (I_REG_ADDR == `GSX_ADDR_LINK_STATUS);
  assign wr_ctrl   = I_REG_WR && (I_REG_ADDR == `GSX_ADDR_EXT_CTRL);
  assign wr_data   = I_REG_WR && (I_REG_ADDR == `GSX_ADDR_EXT_WDATA);
  assign idle_err  = I_SYMBOL_EN && I_RX_IDLE && I_TX_SEND_N && I_RX_ERROR;

  // status state
  logic                       fault_r;
  logic                       fault_nxt;
  logic                       master_r;
  logic                       loc_ok_r;
  logic                       rem_ok_r;
  logic                       partner_gig_full_duplex_r;
  logic                       partner_gig_half_duplex_r;
  gig_status_pkg::err_count_t idle_cnt_r;
  gig_status_pkg::err_count_t idle_cnt_nxt;

  always_comb
  begin
    fault_nxt = fault_r;
    if (rd_status)
    begin
      fault_nxt = 1'b0;
    end
    if (I_MS_FAULT)
    begin
      fault_nxt = 1'b1;
    end
    idle_cnt_nxt = idle_cnt_r;
    if (rd_status)
    begin
      idle_cnt_nxt = `GSX_CNT_RESET;
    end
    if (idle_err)
    begin
      // an error in the clearing cycle counts as the first of the new run
      if (rd_status)
      begin
        idle_cnt_nxt = 8'h01;
      end
      else if (idle_cnt_r != `GSX_CNT_MAX)
      begin
        idle_cnt_nxt = idle_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      fault_r                   <= 1'b0;
      master_r                  <= 1'b0;
      loc_ok_r                  <= 1'b0;
      rem_ok_r                  <= 1'b0;
      partner_gig_full_duplex_r <= 1'b0;
      partner_gig_half_duplex_r <= 1'b0;
      idle_cnt_r                <= `GSX_CNT_RESET;
    end
    else
    begin
      fault_r                   <= fault_nxt;
      master_r                  <= I_MS_MASTER;
      loc_ok_r                  <= I_LOC_RCVR_OK;
      rem_ok_r                  <= I_REM_RCVR_OK;
      partner_gig_full_duplex_r <= I_PARTNER_GIG_FULL_DUPLEX;
      partner_gig_half_duplex_r <= I_PARTNER_GIG_HALF_DUPLEX;
      idle_cnt_r                <= idle_cnt_nxt;
    end
  end

  // extended window state
  logic                      dir_r;
  logic                      dir_nxt;
  logic                      page_r;
  logic                      page_nxt;
  gig_status_pkg::ext_addr_t addr_r;
  gig_status_pkg::ext_addr_t addr_nxt;
  gig_status_pkg::reg_word_t wdata_r;
  gig_status_pkg::reg_word_t wdata_nxt;
  gig_status_pkg::reg_word_t xrdata_r;
  gig_status_pkg::reg_word_t xrdata_nxt;
  logic                      ext_wr_r;
  logic                      ext_wr_nxt;
  logic                      ext_rd_r;
  logic                      ext_rd_nxt;

  always_comb
  begin
    dir_nxt    = dir_r;
    page_nxt   = page_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    xrdata_nxt = xrdata_r;
    ext_wr_nxt = 1'b0;
    ext_rd_nxt = 1'b0;
    if (wr_ctrl)
    begin
      dir_nxt    = I_REG_WDATA[`GSX_CTRL_DIR];
      page_nxt   = I_REG_WDATA[`GSX_CTRL_PAGE];
      addr_nxt   = I_REG_WDATA[`GSX_CTRL_ADDR_MSB:0];
      ext_rd_nxt = !I_REG_WDATA[`GSX_CTRL_DIR];
    end
    if (wr_data)
    begin
      wdata_nxt  = I_REG_WDATA;
      // a data write only reaches the extended space in write direction
      ext_wr_nxt = dir_r;
    end
    if (ext_rd_r)
    begin
      xrdata_nxt = I_EXT_RDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      dir_r    <= 1'b0;
      page_r   <= 1'b0;
      addr_r   <= 8'h00;
      wdata_r  <= `GSX_WORD_RESET;
      xrdata_r <= `GSX_WORD_RESET;
      ext_wr_r <= 1'b0;
      ext_rd_r <= 1'b0;
    end
    else
    begin
      dir_r    <= dir_nxt;
      page_r   <= page_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      xrdata_r <= xrdata_nxt;
      ext_wr_r <= ext_wr_nxt;
      ext_rd_r <= ext_rd_nxt;
    end
  end

  assign O_EXT_WR    = ext_wr_r;
  assign O_EXT_RD    = ext_rd_r;
  assign O_EXT_PAGE  = page_r;
  assign O_EXT_ADDR  = addr_r;
  assign O_EXT_WDATA = wdata_r;

  // read mux, answered one cycle after the strobe
  gig_status_pkg::reg_word_t rdata_r;
  gig_status_pkg::reg_word_t rdata_nxt;
  logic                      rvalid_r;
  logic                      rvalid_nxt;

  always_comb
  begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = I_REG_RD;
    if (I_REG_RD)
    begin
      rdata_nxt = `GSX_WORD_RESET;
      unique case (I_REG_ADDR)
        `GSX_ADDR_LINK_STATUS:
        begin
          rdata_nxt[`GSX_LS_MS_FAULT]          = fault_r;
          rdata_nxt[`GSX_LS_MS_MASTER]         = master_r;
          rdata_nxt[`GSX_LS_LOC_RCVR]          = loc_ok_r;
          rdata_nxt[`GSX_LS_REM_RCVR]          = rem_ok_r;
          rdata_nxt[`GSX_LS_LP_FD]             = partner_gig_full_duplex_r;
          rdata_nxt[`GSX_LS_LP_HD]             = partner_gig_half_duplex_r;
          rdata_nxt[`GSX_LS_IDLE_CNT_MSB:0]    = idle_cnt_r;
        end
        `GSX_ADDR_EXT_CTRL:
        begin
          rdata_nxt[`GSX_CTRL_DIR]             = dir_r;
          rdata_nxt[`GSX_CTRL_PAGE]            = page_r;
          rdata_nxt[`GSX_CTRL_ADDR_MSB:0]      = addr_r;
        end
        `GSX_ADDR_EXT_WDATA: rdata_nxt = wdata_r;
        `GSX_ADDR_EXT_RDATA: rdata_nxt = xrdata_r;
        `GSX_ADDR_ABILITY:   rdata_nxt = `GSX_ABILITY_VALUE;
        default:             rdata_nxt = `GSX_WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      rdata_r  <= `GSX_WORD_RESET;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign O_REG_RDATA  = rdata_r;
  assign O_REG_RVALID = rvalid_r;

  // checks
  sequence s_ctrl_read_req;
    wr_ctrl && !I_REG_WDATA[`GSX_CTRL_DIR];
  endsequence

  sequence s_ext_fetch;
    ##1 (O_EXT_RD && !O_EXT_WR) ##1 (xrdata_r == $past(I_EXT_RDATA));
  endsequence

  property p_fault_set;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      I_MS_FAULT |=> fault_r;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_fault_hold;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (fault_r && !rd_status) |=> fault_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost before read");

  property p_fault_clear;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (rd_status && fault_r && !I_MS_FAULT) |=> (O_REG_RDATA[15] && !fault_r);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault read/clear wrong");

  property p_role_report;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (rd_status && $stable(I_MS_MASTER) && $past(I_RST_N))
      |=> (O_REG_RDATA[14] == $past(I_MS_MASTER, 2));
  endproperty
  a_role_report: assert property (p_role_report) else $error("role bit mismatch");

  property p_cnt_clear;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (rd_status && !idle_err) |=> (idle_cnt_r == 8'h00);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");

  property p_cnt_inc;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (idle_err && !rd_status && idle_cnt_r != 8'hff)
      |=> (idle_cnt_r == $past(idle_cnt_r) + 8'h01);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count not incremented");

  property p_ext_read;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      s_ctrl_read_req |-> s_ext_fetch;
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extended read not fetched");

  property p_ext_write;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (wr_data && dir_r) |=> (O_EXT_WR && O_EXT_WDATA == $past(I_REG_WDATA));
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("extended write not issued");

  property p_no_write_in_read_dir;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (wr_data && !dir_r) |=> !O_EXT_WR;
  endproperty
  a_no_write_in_read_dir: assert property (p_no_write_in_read_dir) else $error("bad write");

  property p_ability;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (I_REG_RD && I_REG_ADDR == 5'h0f) |=> (O_REG_RVALID && O_REG_RDATA == 16'h3000);
  endproperty
  a_ability: assert property (p_ability) else $error("ability word wrong");

  property p_reserved_zero;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (I_REG_RD && I_REG_ADDR == 5'h0b) |=> (O_REG_RDATA[14:9] == 6'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

endmodule : gigabit_status_ext_access

// *** verif/ext_space_model.sv ***
// behavioural model of the extended register space behind the window
`timescale 1ns/1ps
module ext_space_model (
  input  wire logic                       i_clk,
  input  wire logic                       i_ext_wr,
  input  wire logic                       i_ext_rd,
  input  wire logic                       i_ext_page,
  input  wire gig_status_pkg::ext_addr_t  i_ext_addr,
  input  wire gig_status_pkg::reg_word_t  i_ext_wdata,
  output var  gig_status_pkg::reg_word_t  o_ext_rdata
);
  gig_status_pkg::reg_word_t mem [0:511];
  gig_status_pkg::reg_word_t last_r = 16'h0000;
  always @(posedge i_clk)
  begin
    if (i_ext_wr)
      mem[{i_ext_page, i_ext_addr}] <= i_ext_wdata;
    if (i_ext_rd)
      last_r <= o_ext_rdata;
  end
  // outside a fetch cycle the lines show the inverse of the last answer
  assign o_ext_rdata = i_ext_rd ? mem[{i_ext_page, i_ext_addr}] : ~last_r;
endmodule : ext_space_model

// *** verif/tb_gigabit_status_ext_access.sv ***
// self-checking bench of the gigabit status register group
`timescale 1ns/1ps
`include "gig_status_cfg.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_gigabit_status_ext_access;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  gig_status_pkg::reg_addr_t reg_addr = 5'h00;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  gig_status_pkg::reg_word_t reg_wdata = 16'h0000;
  gig_status_pkg::reg_word_t rdata;
  logic                      rvalid;
  logic                      ms_fault = 1'b0;
  logic                      ms_master = 1'b0;
  logic                      loc_ok = 1'b0;
  logic                      rem_ok = 1'b0;
  logic                      lp_fd = 1'b0;
  logic                      lp_hd = 1'b0;
  logic                      sym_en = 1'b0;
  logic                      rx_idle = 1'b1;
  logic                      tx_send_n = 1'b1;
  logic                      rx_err = 1'b0;
  logic                      ext_wr;
  logic                      ext_rd;
  logic                      ext_page;
  gig_status_pkg::ext_addr_t ext_addr;
  gig_status_pkg::reg_word_t ext_wdata;
  gig_status_pkg::reg_word_t ext_rdata;
  int                        bad_count = 0;
  int                        n_checks = 0;

  always #2 clk = ~clk;

  gigabit_status_ext_access u_dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_ADDR(reg_addr), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .I_MS_FAULT(ms_fault), .I_MS_MASTER(ms_master), .I_LOC_RCVR_OK(loc_ok),
    .I_REM_RCVR_OK(rem_ok), .I_PARTNER_GIG_FULL_DUPLEX(lp_fd),
    .I_PARTNER_GIG_HALF_DUPLEX(lp_hd), .I_SYMBOL_EN(sym_en), .I_RX_IDLE(rx_idle),
    .I_TX_SEND_N(tx_send_n), .I_RX_ERROR(rx_err), .O_EXT_WR(ext_wr), .O_EXT_RD(ext_rd),
    .O_EXT_PAGE(ext_page), .O_EXT_ADDR(ext_addr), .O_EXT_WDATA(ext_wdata),
    .I_EXT_RDATA(ext_rdata)
  );

  ext_space_model u_ext (
    .i_clk(clk), .i_ext_wr(ext_wr), .i_ext_rd(ext_rd), .i_ext_page(ext_page),
    .i_ext_addr(ext_addr), .i_ext_wdata(ext_wdata), .o_ext_rdata(ext_rdata)
  );

  task automatic reg_write(input gig_status_pkg::reg_addr_t a, input gig_status_pkg::reg_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_write

  // the answer is flagged valid for exactly one cycle after the strobe edge
  task automatic reg_check(input gig_status_pkg::reg_addr_t a, input gig_status_pkg::reg_word_t e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    `CHK("read valid", 1'b1, rvalid)
    `CHK("read data", e, rdata)
    @(posedge clk);
    #1;
  endtask : reg_check

  task automatic t_reset_values;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0000);
    reg_check(`GSX_ADDR_EXT_CTRL, 16'h0000);
    reg_check(`GSX_ADDR_EXT_WDATA, 16'h0000);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'h0000);
    reg_check(`GSX_ADDR_ABILITY, 16'h3000);
    reg_check(5'h01, 16'h0000);
    reg_write(`GSX_ADDR_ABILITY, 16'hcfff);
    reg_check(`GSX_ADDR_ABILITY, 16'h3000);
  endtask : t_reset_values

  task automatic t_idle_count;
    sym_en = 1'b1;
    rx_err = 1'b1;
    repeat (3) @(posedge clk);
    #1 rx_idle = 1'b0;
    @(posedge clk);
    #1 tx_send_n = 1'b0;
    rx_idle = 1'b1;
    @(posedge clk);
    #1 sym_en = 1'b0;
    @(posedge clk);
    #1 tx_send_n = 1'b1;
    @(posedge clk);
    #1 rx_err = 1'b0;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0003);
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0000);
    // an error in the clearing read cycle starts the new count at one
    sym_en = 1'b1;
    rx_err = 1'b1;
    reg_addr = `GSX_ADDR_LINK_STATUS;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 sym_en = 1'b0;
    rx_err = 1'b0;
    reg_rd = 1'b0;
    `CHK("clearing read", 16'h0000, rdata)
    @(posedge clk);
    #1;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0001);
    // count stops at its top value
    sym_en = 1'b1;
    rx_err = 1'b1;
    repeat (260) @(posedge clk);
    #1 sym_en = 1'b0;
    rx_err = 1'b0;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h00ff);
  endtask : t_idle_count

  task automatic t_fault;
    ms_fault = 1'b1;
    @(posedge clk);
    #1 ms_fault = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h8000);
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0000);
    // a conflict in the clearing read cycle must survive the clear
    ms_fault = 1'b1;
    reg_addr = `GSX_ADDR_LINK_STATUS;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 ms_fault = 1'b0;
    reg_rd = 1'b0;
    `CHK("racing read", 16'h0000, rdata)
    @(posedge clk);
    #1;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h8000);
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h0000);
  endtask : t_fault

  task automatic t_status_mirror;
    {ms_master, loc_ok, rem_ok, lp_fd, lp_hd} = 5'h1f;
    repeat (2) @(posedge clk);
    #1;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h7c00);
    {ms_master, loc_ok, rem_ok, lp_fd, lp_hd} = 5'h0a;
    repeat (2) @(posedge clk);
    #1;
    reg_check(`GSX_ADDR_LINK_STATUS, 16'h2800);
  endtask : t_status_mirror

  task automatic t_ext_window;
    reg_write(`GSX_ADDR_EXT_CTRL, 16'hfeff);
    reg_check(`GSX_ADDR_EXT_CTRL, 16'h80ff);
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h8105);
    reg_write(`GSX_ADDR_EXT_WDATA, 16'hbeef);
    reg_check(`GSX_ADDR_EXT_WDATA, 16'hbeef);
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h80ff);
    reg_write(`GSX_ADDR_EXT_WDATA, 16'h5a5a);
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h0105);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'hbeef);
    reg_write(`GSX_ADDR_EXT_WDATA, 16'h1234);
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h00ff);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'h5a5a);
    reg_write(`GSX_ADDR_EXT_RDATA, 16'hffff);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'h5a5a);
    // the data write in read direction must not have reached page 1 address 05
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h0105);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'hbeef);
  endtask : t_ext_window

  task automatic t_mid_reset;
    reg_write(`GSX_ADDR_EXT_CTRL, 16'h81a5);
    `CHK("ext page", 1'b1, ext_page)
    `CHK("ext addr", 8'ha5, ext_addr)
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("ext addr after reset", 8'h00, ext_addr)
    reg_check(`GSX_ADDR_EXT_CTRL, 16'h0000);
    reg_check(`GSX_ADDR_EXT_WDATA, 16'h0000);
    reg_check(`GSX_ADDR_EXT_RDATA, 16'h0000);
  endtask : t_mid_reset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset_values();
    t_idle_count();
    t_fault();
    t_status_mirror();
    t_ext_window();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : tb_gigabit_status_ext_access
